//--- logic/bridge_claim_decode.sv
`timescale 1ns/1ps
`default_nettype none
module bridge_claim_decode #(
  parameter int FUNC_COUNT = 1
) (
  input  wire logic                    sys_clk,
  input  wire logic                    nrst,
  input  wire claim_pkg::addr_phase_t  pri_phase,
  input  wire claim_pkg::addr_phase_t  sec_phase,
  input  wire logic                    pri_io_hit,
  input  wire logic                    pri_mem_hit,
  input  wire logic                    sec_io_hit,
  input  wire logic                    sec_mem_hit,
  input  wire logic                    busnum_we,
  input  wire logic [31:0]             busnum_wdata,
  output logic [31:0]                  busnum_rdata,
  output claim_pkg::claim_out_t        pri_claim,
  output claim_pkg::claim_out_t        sec_claim,
  output logic [3:0]                   downstream_cmd_lanes
);

  // The function field is three bits wide, so no more than eight can be decoded.
  if (FUNC_COUNT < 1 || FUNC_COUNT > 8) begin : g_bad_func_count
    $error("FUNC_COUNT must be 1 to 8");
  end

  // ---------------------------------------------------------------------------
  // Reset release
  // ---------------------------------------------------------------------------
  logic [1:0] rst_sync_r;
  logic       rst_n;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  // ---------------------------------------------------------------------------
  // Field decode
  // ---------------------------------------------------------------------------
  logic [7:0] p_bus, s_bus;
  logic       p_t0, p_t1, p_rd, p_wr, p_sp;
  logic       s_t0, s_t1, s_rd, s_wr, s_sp;

  cfg_addr_split u_pri_split (
    .addr           (pri_phase.addr),
    .cmd            (pri_phase.cmd),
    .bus            (p_bus),
    .is_type0       (p_t0),
    .is_type1       (p_t1),
    .is_cfg_rd      (p_rd),
    .is_cfg_wr      (p_wr),
    .is_special_req (p_sp)
  );

  cfg_addr_split u_sec_split (
    .addr           (sec_phase.addr),
    .cmd            (sec_phase.cmd),
    .bus            (s_bus),
    .is_type0       (s_t0),
    .is_type1       (s_t1),
    .is_cfg_rd      (s_rd),
    .is_cfg_wr      (s_wr),
    .is_special_req (s_sp)
  );

  // Range-decoded commands share one classifier for both ports.
  function automatic logic is_range_cmd(input logic [3:0] c, input logic io, input logic mem);
    logic r;
    r = 1'b0;
    case (c)
      claim_pkg::CMD_IO_RD, claim_pkg::CMD_IO_WR: r = io;
      claim_pkg::CMD_MEM_RD, claim_pkg::CMD_MEM_WR, claim_pkg::CMD_MEM_RDM,
      claim_pkg::CMD_MEM_RDL, claim_pkg::CMD_MEM_WRI: r = mem;
      default: r = 1'b0;
    endcase
    return r;
  endfunction : is_range_cmd

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [31:0]           busnum;
    claim_pkg::claim_out_t pri;
    claim_pkg::claim_out_t sec;
    logic [3:0]            lanes;
  } state_t;

  state_t st_r, st_nxt;

  logic [7:0] pri_num, sec_num, sub_num;
  logic       p_sec_hit, p_deep_hit, s_in_range, s_pri_hit;
  logic [2:0] p_func;

  always_comb begin
    pri_num    = st_r.busnum[7:0];
    sec_num    = st_r.busnum[15:8];
    sub_num    = st_r.busnum[23:16];
    p_func     = pri_phase.addr[claim_pkg::FUNC_LSB +: 3];
    p_sec_hit  = p_bus == sec_num;
    p_deep_hit = p_bus > sec_num && p_bus <= sub_num;
    s_in_range = s_bus >= sec_num && s_bus <= sub_num;
    s_pri_hit  = s_bus == pri_num;
  end

  always_comb begin
    st_nxt     = st_r;
    if (busnum_we) begin
      st_nxt.busnum = busnum_wdata;
    end

    // Primary port.
    st_nxt.pri = '{claim: 1'b0, act: claim_pkg::ACT_NONE, out_cmd: pri_phase.cmd,
                   out_addr: pri_phase.addr};
    if (pri_phase.valid) begin
      if ((p_rd || p_wr) && p_t0) begin
        if (pri_phase.idsel && 32'(p_func) < FUNC_COUNT) begin
          st_nxt.pri.claim = 1'b1;
          st_nxt.pri.act   = claim_pkg::ACT_LOCAL;
        end
      end else if (p_sp) begin
        if (p_sec_hit) begin
          st_nxt.pri.claim   = 1'b1;
          st_nxt.pri.act     = claim_pkg::ACT_SPECIAL;
          st_nxt.pri.out_cmd = claim_pkg::CMD_SPECIAL;
        end else if (p_deep_hit) begin
          st_nxt.pri.claim = 1'b1;
          st_nxt.pri.act   = claim_pkg::ACT_TYPE1;
        end
      end else if ((p_rd || p_wr) && p_t1) begin
        if (p_sec_hit) begin
          st_nxt.pri.claim         = 1'b1;
          st_nxt.pri.act           = claim_pkg::ACT_TYPE0;
          st_nxt.pri.out_addr[1:0] = claim_pkg::TYPE0_CODE;
        end else if (p_deep_hit) begin
          st_nxt.pri.claim = 1'b1;
          st_nxt.pri.act   = claim_pkg::ACT_TYPE1;
        end
      end else if (is_range_cmd(pri_phase.cmd, pri_io_hit, pri_mem_hit)) begin
        st_nxt.pri.claim = 1'b1;
        st_nxt.pri.act   = claim_pkg::ACT_TYPE1;
      end
    end

    // Secondary port.
    st_nxt.sec = '{claim: 1'b0, act: claim_pkg::ACT_NONE, out_cmd: sec_phase.cmd,
                   out_addr: sec_phase.addr};
    if (sec_phase.valid) begin
      if (s_sp) begin
        if (s_pri_hit) begin
          st_nxt.sec.claim   = 1'b1;
          st_nxt.sec.act     = claim_pkg::ACT_SPECIAL;
          st_nxt.sec.out_cmd = claim_pkg::CMD_SPECIAL;
        end else if (!s_in_range) begin
          st_nxt.sec.claim = 1'b1;
          st_nxt.sec.act   = claim_pkg::ACT_TYPE1;
        end
      end else if (s_rd || s_wr) begin
        st_nxt.sec.claim = 1'b0;
      end else if (is_range_cmd(sec_phase.cmd, sec_io_hit, sec_mem_hit)) begin
        st_nxt.sec.claim = 1'b1;
        st_nxt.sec.act   = claim_pkg::ACT_TYPE1;
      end
    end

    // A local type 0 access stays inside the bridge, so nothing reaches the far lanes.
    st_nxt.lanes = (st_nxt.pri.claim && st_nxt.pri.act != claim_pkg::ACT_LOCAL) ?
                   st_nxt.pri.out_cmd : 4'h0;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '{busnum: claim_pkg::BUSNUM_RESET,
                pri: '{claim: 1'b0, act: claim_pkg::ACT_NONE, out_cmd: 4'h0, out_addr: 32'h0},
                sec: '{claim: 1'b0, act: claim_pkg::ACT_NONE, out_cmd: 4'h0, out_addr: 32'h0},
                lanes: 4'h0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign busnum_rdata         = st_r.busnum;
  assign pri_claim            = st_r.pri;
  assign sec_claim            = st_r.sec;
  assign downstream_cmd_lanes = st_r.lanes;

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  sequence s_pri_t1_sec;
    pri_phase.valid && (p_rd || p_wr) && p_t1 && !p_sp && p_bus == sec_num;
  endsequence

  property p_type0_conv;
    @(posedge sys_clk) disable iff (!rst_n)
      s_pri_t1_sec |=> pri_claim.claim && pri_claim.out_addr[1:0] == 2'h0;
  endproperty
  a_type0_conv: assert property (p_type0_conv) else $error("type 0 conversion missed");

  property p_pri_ignore;
    @(posedge sys_clk) disable iff (!rst_n)
      (pri_phase.valid && (p_rd || p_wr) && p_t1 && (p_bus < sec_num || p_bus > sub_num))
      |=> !pri_claim.claim;
  endproperty
  a_pri_ignore: assert property (p_pri_ignore) else $error("out-of-range type 1 claimed");

  property p_sec_cfg;
    @(posedge sys_clk) disable iff (!rst_n)
      (sec_phase.valid && (s_rd || (s_wr && !s_sp))) |=> !sec_claim.claim;
  endproperty
  a_sec_cfg: assert property (p_sec_cfg) else $error("secondary config claimed");

  property p_special_dn;
    @(posedge sys_clk) disable iff (!rst_n)
      (pri_phase.valid && p_sp && p_bus == sec_num)
      |=> pri_claim.claim && pri_claim.out_cmd == 4'h1;
  endproperty
  a_special_dn: assert property (p_special_dn) else $error("special cycle not run");

  property p_sec_sp_ign;
    @(posedge sys_clk) disable iff (!rst_n)
      (sec_phase.valid && s_sp && !s_pri_hit && s_in_range) |=> !sec_claim.claim;
  endproperty
  a_sec_sp_ign: assert property (p_sec_sp_ign) else $error("in-range special claimed");

  property p_no_intack;
    @(posedge sys_clk) disable iff (!rst_n)
      (pri_phase.valid && pri_phase.cmd <= 4'h1) |=> !pri_claim.claim;
  endproperty
  a_no_intack: assert property (p_no_intack) else $error("intack or special claimed");

  property p_type0_local;
    @(posedge sys_clk) disable iff (!rst_n)
      (pri_phase.valid && (p_rd || p_wr) && p_t0 && !pri_phase.idsel) |=> !pri_claim.claim;
  endproperty
  a_type0_local: assert property (p_type0_local) else $error("type 0 claimed unselected");

  property p_sec_up;
    @(posedge sys_clk) disable iff (!rst_n)
      (sec_phase.valid && s_sp && s_pri_hit) |=> sec_claim.act == claim_pkg::ACT_SPECIAL;
  endproperty
  a_sec_up: assert property (p_sec_up) else $error("upstream special missed");

endmodule : bridge_claim_decode
`default_nettype wire

//--- logic/claim_pkg.sv
`default_nettype none
package claim_pkg;

  // ---------------------------------------------------------------------------
  // Bus command codes
  // ---------------------------------------------------------------------------
  localparam logic [3:0] CMD_INTACK   = 4'h0;
  localparam logic [3:0] CMD_SPECIAL  = 4'h1;
  localparam logic [3:0] CMD_IO_RD    = 4'h2;
  localparam logic [3:0] CMD_IO_WR    = 4'h3;
  localparam logic [3:0] CMD_MEM_RD   = 4'h6;
  localparam logic [3:0] CMD_MEM_WR   = 4'h7;
  localparam logic [3:0] CMD_CFG_RD   = 4'hA;
  localparam logic [3:0] CMD_CFG_WR   = 4'hB;
  localparam logic [3:0] CMD_MEM_RDM  = 4'hC;
  localparam logic [3:0] CMD_DAC      = 4'hD;
  localparam logic [3:0] CMD_MEM_RDL  = 4'hE;
  localparam logic [3:0] CMD_MEM_WRI  = 4'hF;

  // ---------------------------------------------------------------------------
  // Configuration address fields
  // ---------------------------------------------------------------------------
  localparam int          BUS_LSB       = 16;
  localparam int          DEV_LSB       = 11;
  localparam int          FUNC_LSB      = 8;
  localparam logic [4:0]  SPECIAL_DEV   = 5'h1F;
  localparam logic [2:0]  SPECIAL_FUNC  = 3'h7;
  localparam logic [1:0]  TYPE0_CODE    = 2'h0;
  localparam logic [1:0]  TYPE1_CODE    = 2'h1;

  // Bus number dword, config offset 18h.
  localparam logic [7:0]  BUSNUM_OFFSET = 8'h18;
  localparam logic [31:0] BUSNUM_RESET  = 32'h0000_0000;

  // ---------------------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic        valid;
    logic [3:0]  cmd;
    logic [31:0] addr;
    logic        idsel;
  } addr_phase_t;

  typedef enum logic [4:0] {
    ACT_NONE    = 5'h01,
    ACT_LOCAL   = 5'h02,
    ACT_TYPE0   = 5'h04,
    ACT_TYPE1   = 5'h08,
    ACT_SPECIAL = 5'h10
  } claim_act_t;

  typedef struct packed {
    logic        claim;
    claim_act_t  act;
    logic [3:0]  out_cmd;
    logic [31:0] out_addr;
  } claim_out_t;

endpackage : claim_pkg
`default_nettype wire

//--- logic/cfg_addr_split.sv
`timescale 1ns/1ps
`default_nettype none
// Splits a configuration address phase into its fields and classifies it.
module cfg_addr_split (
  input  wire logic [31:0] addr,
  input  wire logic [3:0]  cmd,
  output logic      [7:0]  bus,
  output logic             is_type0,
  output logic             is_type1,
  output logic             is_cfg_rd,
  output logic             is_cfg_wr,
  output logic             is_special_req
);
  logic [4:0] dev;
  logic [2:0] func;

  always_comb begin
    bus            = addr[claim_pkg::BUS_LSB +: 8];
    dev            = addr[claim_pkg::DEV_LSB +: 5];
    func           = addr[claim_pkg::FUNC_LSB +: 3];
    is_type0       = addr[1:0] == claim_pkg::TYPE0_CODE;
    is_type1       = addr[1:0] == claim_pkg::TYPE1_CODE;
    is_cfg_rd      = cmd == claim_pkg::CMD_CFG_RD;
    is_cfg_wr      = cmd == claim_pkg::CMD_CFG_WR;
    is_special_req = is_cfg_wr && is_type1 && dev == claim_pkg::SPECIAL_DEV
                     && func == claim_pkg::SPECIAL_FUNC;
  end
endmodule : cfg_addr_split
`default_nettype wire

//--- dv/phase_initiator.sv
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------------------
// Address-phase initiator on one side of the bridge
// ---------------------------------------------------------------------------
module phase_initiator (
  output var claim_pkg::addr_phase_t phase
);
  initial phase = '0;

  // Outside an address phase the command and address lines show the inverse of the last value.
  // A decoder that samples them while valid is low then sees changing junk.
  task automatic issue(input claim_pkg::addr_phase_t ph);
    if (ph.valid) begin
      phase = ph;
    end else begin
      phase.valid = 1'b0;
      phase.cmd   = ~phase.cmd;
      phase.addr  = ~phase.addr;
    end
  endtask : issue
endmodule : phase_initiator
`default_nettype wire

//--- dv/test_bridge_claim_decode.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin miscompares++; \
  $display("[ERR] %0t got %h expected %h", $time, got, exp); end end
module test_bridge_claim_decode;
  localparam logic [3:0] CRD = claim_pkg::CMD_CFG_RD;
  localparam logic [3:0] CWR = claim_pkg::CMD_CFG_WR;
  logic                   sys_clk;
  logic                   nrst;
  claim_pkg::addr_phase_t pri_phase;
  claim_pkg::addr_phase_t sec_phase;
  logic [3:0]             hits;
  logic                   busnum_we;
  logic [31:0]            busnum_wdata;
  logic [31:0]            busnum_rdata;
  claim_pkg::claim_out_t  pri_claim;
  claim_pkg::claim_out_t  sec_claim;
  logic [3:0]             downstream_cmd_lanes;
  claim_pkg::claim_out_t  pri_exp;
  claim_pkg::claim_out_t  sec_exp;
  logic [7:0]             pri_n;
  logic [7:0]             sec_n;
  logic [7:0]             sub_n;
  logic [3:0]             rc [7] = '{4'h2, 4'h3, 4'h6, 4'h7, 4'hC, 4'hE, 4'hF};
  int                     miscompares;
  int                     tests_run;

  bridge_claim_decode #(.FUNC_COUNT(1)) u_bridge_claim_decode (
    .sys_clk(sys_clk), .nrst(nrst), .pri_phase(pri_phase), .sec_phase(sec_phase),
    .pri_io_hit(hits[0]), .pri_mem_hit(hits[1]), .sec_io_hit(hits[2]),
    .sec_mem_hit(hits[3]), .busnum_we(busnum_we), .busnum_wdata(busnum_wdata),
    .busnum_rdata(busnum_rdata), .pri_claim(pri_claim), .sec_claim(sec_claim),
    .downstream_cmd_lanes(downstream_cmd_lanes));
  phase_initiator u_pri_initiator (.phase(pri_phase));
  phase_initiator u_sec_initiator (.phase(sec_phase));

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  // ---------------------------------------------------------------------------
  // Expectation model
  // ---------------------------------------------------------------------------
  function automatic logic [31:0] mk(input logic [7:0] bus, input logic [4:0] dev,
                                     input logic [2:0] fn, input logic t1);
    return {8'h00, bus, dev, fn, 6'h00, 1'b0, t1};
  endfunction : mk

  function automatic claim_pkg::claim_out_t expect_of(input logic sec_side,
      input claim_pkg::addr_phase_t ph, input logic io, input logic mem);
    claim_pkg::claim_out_t r;
    claim_pkg::claim_act_t a;
    logic [7:0]            b;
    logic                  t1;
    logic                  cfg;
    logic                  spc;
    b   = ph.addr[23:16];
    t1  = ph.addr[1:0] == claim_pkg::TYPE1_CODE;
    cfg = ph.cmd == CRD || ph.cmd == CWR;
    spc = ph.cmd == CWR && t1 && ph.addr[15:8] == 8'hFF;
    r   = '{1'b0, claim_pkg::ACT_NONE, ph.cmd, ph.addr};
    a   = claim_pkg::ACT_TYPE1;
    if (!ph.valid) return r;
    if (ph.cmd inside {4'h2, 4'h3}) r.claim = io;
    else if (ph.cmd inside {4'h6, 4'h7, 4'hC, 4'hE, 4'hF}) r.claim = mem;
    else if (cfg && !sec_side && !t1) begin
      r.claim = ph.idsel && ph.addr[10:8] == 3'h0;
      a       = claim_pkg::ACT_LOCAL;
    end else if (cfg && !sec_side && b == sec_n) begin
      r.claim   = 1'b1;
      a         = spc ? claim_pkg::ACT_SPECIAL : claim_pkg::ACT_TYPE0;
      r.out_cmd = spc ? claim_pkg::CMD_SPECIAL : ph.cmd;
      if (!spc) r.out_addr[1:0] = claim_pkg::TYPE0_CODE;
    end else if (cfg && !sec_side && b > sec_n && b <= sub_n) r.claim = 1'b1;
    else if (spc && sec_side && b == pri_n) begin
      r.claim   = 1'b1;
      a         = claim_pkg::ACT_SPECIAL;
      r.out_cmd = claim_pkg::CMD_SPECIAL;
    end else if (spc && sec_side && (b < sec_n || b > sub_n)) r.claim = 1'b1;
    r.act = r.claim ? a : claim_pkg::ACT_NONE;
    return r;
  endfunction : expect_of

  function automatic claim_pkg::addr_phase_t rnd_phase();
    logic [3:0]  codes [11] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h6, 4'h7, 4'hA, 4'hB, 4'hC,
                                4'hE, 4'hF};
    logic [31:0] a;
    a          = $urandom;
    a[23:16]   = 8'($urandom_range(0, 12));
    a[1]       = 1'b0;
    if ($urandom_range(0, 2) == 0) a[15:8] = 8'hFF;
    return '{$urandom_range(0, 3) != 0, codes[$urandom_range(0, 10)], a, 1'($urandom)};
  endfunction : rnd_phase

  // ---------------------------------------------------------------------------
  // Drivers and checks
  // ---------------------------------------------------------------------------
  task automatic check_side(input claim_pkg::claim_out_t got,
                            input claim_pkg::claim_out_t ex);
    `CHK(got.claim, ex.claim)
    `CHK(got.act, ex.act)
    if (ex.claim && ex.act != claim_pkg::ACT_LOCAL) `CHK(got.out_cmd, ex.out_cmd)
    if (ex.act == claim_pkg::ACT_TYPE1) `CHK(got.out_addr, ex.out_addr)
    if (ex.act == claim_pkg::ACT_TYPE0) `CHK(got.out_addr, ex.out_addr)
  endtask : check_side

  // A local claim is never forwarded, so the far lanes stay quiet for it.
  function automatic logic [3:0] exp_lanes(input claim_pkg::claim_out_t ex);
    return (ex.claim && ex.act != claim_pkg::ACT_LOCAL) ? ex.out_cmd : 4'h0;
  endfunction : exp_lanes

  // Checks the answer to the previous phase, then launches the next one.
  task automatic step(input claim_pkg::addr_phase_t p, input claim_pkg::addr_phase_t s,
                      input logic [3:0] h);
    @(negedge sys_clk);
    check_side(pri_claim, pri_exp);
    check_side(sec_claim, sec_exp);
    `CHK(downstream_cmd_lanes, exp_lanes(pri_exp))
    u_pri_initiator.issue(p);
    u_sec_initiator.issue(s);
    hits    = h;
    pri_exp = expect_of(1'b0, p, h[0], h[1]);
    sec_exp = expect_of(1'b1, s, h[2], h[3]);
  endtask : step

  task automatic po(input logic [3:0] c, input logic [31:0] a, input logic i,
                    input logic [3:0] h);
    step('{1'b1, c, a, i}, '0, h);
  endtask : po

  task automatic so(input logic [3:0] c, input logic [31:0] a, input logic [3:0] h);
    step('0, '{1'b1, c, a, 1'b0}, h);
  endtask : so

  task automatic set_bus(input logic [7:0] p, input logic [7:0] s, input logic [7:0] u);
    step('0, '0, 4'h0);
    busnum_we    = 1'b1;
    busnum_wdata = {8'h40, u, s, p};
    @(negedge sys_clk);
    busnum_we = 1'b0;
    `CHK(busnum_rdata, {8'h40, u, s, p})
    pri_n = p;
    sec_n = s;
    sub_n = u;
  endtask : set_bus

  task automatic results();
    $display("compares %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : results

  initial begin
    #20000;
    miscompares++;
    results();
  end

  initial begin
    nrst         = 1'b0;
    hits         = 4'h0;
    busnum_we    = 1'b0;
    busnum_wdata = 32'h0;
    miscompares  = 0;
    tests_run    = 0;
    pri_exp      = '{1'b0, claim_pkg::ACT_NONE, 4'h0, 32'h0};
    sec_exp      = pri_exp;
    void'($urandom(25191));
    repeat (4) @(negedge sys_clk);
    nrst = 1'b1;
    repeat (3) @(negedge sys_clk);
    `CHK(busnum_rdata, claim_pkg::BUSNUM_RESET)
    set_bus(8'h01, 8'h05, 8'h09);
    po(CRD, mk(8'h05, 5'h02, 3'h0, 1'b1), 1'b0, 4'h0);
    po(CRD, mk(8'h09, 5'h02, 3'h0, 1'b1), 1'b0, 4'h0);
    po(CRD, mk(8'h0A, 5'h02, 3'h0, 1'b1), 1'b0, 4'h0);
    po(CWR, mk(8'h05, 5'h02, 3'h1, 1'b1), 1'b0, 4'h0);
    po(CWR, mk(8'h06, 5'h02, 3'h1, 1'b1), 1'b0, 4'h0);
    po(CWR, mk(8'h04, 5'h02, 3'h1, 1'b1), 1'b0, 4'h0);
    po(CWR, mk(8'h05, 5'h1F, 3'h7, 1'b1), 1'b0, 4'h0);
    po(CWR, mk(8'h05, 5'h1F, 3'h6, 1'b1), 1'b0, 4'h0);
    po(CWR, mk(8'h09, 5'h1F, 3'h7, 1'b1), 1'b0, 4'h0);
    po(CWR, mk(8'h01, 5'h1F, 3'h7, 1'b1), 1'b0, 4'h0);
    po(CWR, mk(8'h00, 5'h00, 3'h0, 1'b0), 1'b1, 4'h0);
    po(CRD, mk(8'h00, 5'h00, 3'h1, 1'b0), 1'b1, 4'h0);
    po(CRD, mk(8'h00, 5'h00, 3'h0, 1'b0), 1'b0, 4'h0);
    po(4'h0, mk(8'h05, 5'h02, 3'h0, 1'b1), 1'b1, 4'hF);
    po(4'h1, mk(8'h05, 5'h02, 3'h0, 1'b1), 1'b1, 4'hF);
    so(CRD, mk(8'h05, 5'h02, 3'h0, 1'b1), 4'h0);
    so(CWR, mk(8'h05, 5'h02, 3'h0, 1'b0), 4'h0);
    so(CWR, mk(8'h20, 5'h02, 3'h0, 1'b1), 4'h0);
    so(CWR, mk(8'h01, 5'h1F, 3'h7, 1'b1), 4'h0);
    so(CWR, mk(8'h20, 5'h1F, 3'h7, 1'b1), 4'h0);
    so(CWR, mk(8'h05, 5'h1F, 3'h7, 1'b1), 4'h0);
    so(CWR, mk(8'h09, 5'h1F, 3'h7, 1'b1), 4'h0);
    so(4'h1, mk(8'h01, 5'h1F, 3'h7, 1'b1), 4'hF);
    for (int j = 0; j < 2; j++) begin
      foreach (rc[i]) step('{1'b1, rc[i], 32'h1000, 1'b0}, '{1'b1, rc[i], 32'h2000, 1'b0},
                           j == 0 ? 4'h5 : 4'hA);
    end
    repeat (300) step(rnd_phase(), rnd_phase(), 4'($urandom));
    set_bus(8'h0B, 8'h03, 8'h03);
    repeat (300) step(rnd_phase(), rnd_phase(), 4'($urandom));
    step('0, '0, 4'h0);
    results();
  end
endmodule : test_bridge_claim_decode
`default_nettype wire
